// ==== common/lmf_defines.vh ====
/*
 * Constants for the LED matrix function register bank: offsets, fields,
 * reset values, magic values and decode codes.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef LMF_DEFINES_VH
`define LMF_DEFINES_VH

`define LMF_HDR_LED          8'h55
`define LMF_OFF_LOCK         8'hFE
`define LMF_OFF_PAGE         8'hFD
`define LMF_LOCK_KEY         8'hC5
`define LMF_LOCK_CLR         8'h00
`define LMF_PAGE_ONE         8'h01
`define LMF_PAGE_RST         8'h00
`define LMF_OFF_DOT_FIRST    8'h01
`define LMF_OFF_DOT_LAST     8'h48
`define LMF_OFF_CFG          8'h50
`define LMF_OFF_GCUR         8'h51
`define LMF_OFF_PULL         8'h52
`define LMF_OFF_THERM        8'h5F
`define LMF_OFF_SPREAD       8'h60
`define LMF_OFF_RESET        8'h8F
`define LMF_OFF_PFUNLOCK     8'hE0
`define LMF_OFF_PFSEL        8'hE2
`define LMF_RESET_KEY        8'hAE

`define LMF_RST_CFG          8'h00
`define LMF_RST_GCUR         8'h00
`define LMF_RST_PULL         8'h33
`define LMF_RST_THERM        8'h00
`define LMF_RST_SPREAD       8'h00
`define LMF_RST_PFUNLOCK     8'h00
`define LMF_RST_PFSEL        3'h0
`define LMF_RST_DOT          8'h00

`define LMF_MASK_CFG         8'hF7
`define LMF_MASK_PULL        8'hF7
`define LMF_MASK_THERM       8'h0F
`define LMF_MASK_SPREAD      8'h1F
`define LMF_MASK_PFUNLOCK    8'h01

`define LMF_SCAN_FOUR        4'h0
`define LMF_SCAN_THREE       4'h1
`define LMF_SCAN_TWO         4'h2
`define LMF_SCAN_STATIC      4'h3
`define LMF_FD_OFF           2'h0
`define LMF_FD_OPEN_A        2'h1
`define LMF_FD_SHORT         2'h2
`define LMF_FD_OPEN_B        2'h3
`define LMF_PFSEL_FAST_B     3'h7

`define LMF_TEMP_140         8'h8C
`define LMF_TEMP_120         8'h78
`define LMF_TEMP_100         8'h64
`define LMF_TEMP_90          8'h5A
`define LMF_PCT_100          7'h64
`define LMF_PCT_75           7'h4B
`define LMF_PCT_55           7'h37
`define LMF_PCT_30           7'h1E
`define LMF_DEV_5            6'h05
`define LMF_DEV_15           6'h0F
`define LMF_DEV_24           6'h18
`define LMF_DEV_34           6'h22
`define LMF_CYC_1980         11'h7BC
`define LMF_CYC_1200         11'h4B0
`define LMF_CYC_820          11'h334
`define LMF_CYC_660          11'h294

`endif

// ==== logic/lmf_dot_mem.v ====
/*
 * Per-dot scale byte memory, one write port and one registered read port.
 * Assumes one clock; there is no clear input, so the writer clears every
 * word by a walk through the write port (DEPTH cycles).
 */
`timescale 1ns/1ps
`include "lmf_defines.vh"
module lmf_dot_mem #(
    parameter DEPTH = 72,
    parameter AW    = 7
) (
    input  wire          clk_in,
    input  wire          wr_en_in,
    input  wire [AW-1:0] wr_addr_in,
    input  wire [7:0]    wr_data_in,
    input  wire [AW-1:0] rd_addr_in,
    output reg  [7:0]    rd_data_out
);
    reg [7:0] mem_ff [0:DEPTH-1];

    always @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_ff[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem_ff[rd_addr_in];
    end
endmodule // lmf_dot_mem

// ==== logic/lmf_func_regs.v ====
/*
 * Page-one function register bank of an 18x4 matrix LED driver.
 * Assumes an upstream serial slave that delivers decoded register writes
 * (header byte, offset, data) as one-cycle strobes synchronous to clk_in.
 */
// Notes on behaviour
// RULE1: one 8-bit scale byte per dot
// RULE2: dot bytes at 01h-48h, page one
// RULE3: scan field decodes four, three, two, static
// RULE4: fault field: off, open, short
// RULE5: open detect runs once per 00-01
// RULE6: short detect runs once per 00-10
// RULE7: shutdown bit 0 holds device off
// RULE8: global current scales all column sinks
// RULE9: phase bit gives 180 degree delay
// RULE10: row pulldown eight-code decode
// RULE11: column pullup same eight-code decode
// RULE12: temperature threshold selects derating start
// RULE13: rolloff code gives current percentage
// RULE14: spread bit enables clock modulation
// RULE15: spread range decodes deviation percent
// RULE16: spread cycle decodes modulation period
// RULE17: writing AEh resets all registers; here the page pointer and its lock keep their values
// RULE18: power-up loads defaults, display blank
// RULE19: frequency select writable only when unlocked
// RULE20: page pointer needs C5h unlock once
// RULE21: LED space writes need 55h header
// RULE22: frequency code halves from 29 kHz
// RULE23: locked frequency writes keep old value
// RULE24: unassigned bits ignore writes
`timescale 1ns/1ps
`include "lmf_defines.vh"
module lmf_func_regs #(
    parameter DOTS = 72,
    parameter AW   = 7
) (
    input  wire          clk_in,
    input  wire          srst_in,
    input  wire          wr_stb_in,
    input  wire [7:0]    wr_header_in,
    input  wire [7:0]    wr_addr_in,
    input  wire [7:0]    wr_data_in,
    input  wire [AW-1:0] dot_sel_in,
    output wire [7:0]    dot_peak_scale_out,
    output reg  [7:0]    page_sel_out,
    output wire          page_lock_open_out,
    output reg  [1:0]    row_count_out,
    output reg           scan_static_out,
    output reg           open_detect_pulse_out,
    output reg           short_detect_pulse_out,
    output reg           shutdown_out,
    output wire [7:0]    global_current_level_out,
    output wire          phase_select_out,
    output reg  [3:0]    row_pulldown_kohm_x2_out,
    output reg           row_pulldown_always_out,
    output reg  [3:0]    column_pullup_kohm_x2_out,
    output reg           column_pullup_always_out,
    output reg  [7:0]    thermal_start_c_out,
    output reg  [6:0]    rolloff_pct_out,
    output wire          spread_enable_out,
    output reg  [5:0]    spread_dev_pct_out,
    output reg  [10:0]   spread_cycle_us_out,
    output wire [2:0]    pwm_freq_select_out,
    output reg  [2:0]    pwm_freq_div_log2_out,
    output wire          clear_busy_out
);
    reg  [7:0]    lock_ff;
    reg  [7:0]    cfg_ff;
    reg  [7:0]    gcur_ff;
    reg  [7:0]    pull_ff;
    reg  [7:0]    therm_ff;
    reg  [7:0]    spread_ff;
    reg  [7:0]    pfunlock_ff;
    reg  [2:0]    pfsel_ff;
    reg  [1:0]    fd_prev_ff;
    reg  [AW-1:0] clr_idx_ff;
    reg           clr_busy_ff;

    wire          led_wr;
    wire          pg1_wr;
    wire          soft_rst;
    wire          dot_wr;
    wire [1:0]    fd_now;
    wire          mem_we;
    wire [AW-1:0] mem_wa;
    wire [7:0]    mem_wd;
    wire [7:0]    pull_rst;

    // Pull resistor decode, shared by rows and columns
    function [4:0] lmf_pull_dec;
        input [2:0] code;
        begin
            case (code)
                3'h0:    lmf_pull_dec = 5'h00;
                3'h1:    lmf_pull_dec = 5'h01;
                3'h2:    lmf_pull_dec = 5'h02;
                3'h3:    lmf_pull_dec = 5'h04;
                3'h4:    lmf_pull_dec = 5'h12;
                3'h5:    lmf_pull_dec = 5'h14;
                3'h6:    lmf_pull_dec = 5'h18;
                default: lmf_pull_dec = 5'h10;
            endcase
        end
    endfunction

    assign led_wr   = wr_stb_in && (wr_header_in == `LMF_HDR_LED);                  // see RULE21
    assign pg1_wr   = led_wr && (page_sel_out == `LMF_PAGE_ONE);                    // see RULE2
    assign soft_rst = pg1_wr && (wr_addr_in == `LMF_OFF_RESET) && (wr_data_in == `LMF_RESET_KEY); // see RULE17
    assign dot_wr   = pg1_wr && (wr_addr_in >= `LMF_OFF_DOT_FIRST) && (wr_addr_in <= `LMF_OFF_DOT_LAST); // see RULE2

    // Dot bytes are cleared by a walk after any reset
    assign mem_we = clr_busy_ff || dot_wr;                                          // see RULE18
    assign mem_wa = clr_busy_ff ? clr_idx_ff : (wr_addr_in[AW-1:0] - {{(AW-1){1'b0}}, 1'b1});
    assign mem_wd = clr_busy_ff ? `LMF_RST_DOT : wr_data_in;
    assign pull_rst = `LMF_RST_PULL;

    lmf_dot_mem #(
        .DEPTH (DOTS),
        .AW    (AW)
    ) u_dot_mem (
        .clk_in      (clk_in),
        .wr_en_in    (mem_we),
        .wr_addr_in  (mem_wa),
        .wr_data_in  (mem_wd),
        .rd_addr_in  (dot_sel_in),
        .rd_data_out (dot_peak_scale_out)                                           // see RULE1
    );

    always @(posedge clk_in) begin
        if (srst_in || soft_rst) begin
            clr_busy_ff <= 1'b1;
            clr_idx_ff  <= {AW{1'b0}};
        end else if (clr_busy_ff) begin
            if (clr_idx_ff == DOTS[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) begin
                clr_busy_ff <= 1'b0;
            end
            clr_idx_ff <= clr_idx_ff + {{(AW-1){1'b0}}, 1'b1};
        end
    end
    assign clear_busy_out = clr_busy_ff;

    // Page pointer and its one-shot write lock
    always @(posedge clk_in) begin
        if (srst_in) begin
            lock_ff      <= `LMF_LOCK_CLR;
            page_sel_out <= `LMF_PAGE_RST;
        end else if (led_wr && wr_addr_in == `LMF_OFF_LOCK) begin
            lock_ff <= wr_data_in;
        end else if (led_wr && wr_addr_in == `LMF_OFF_PAGE && lock_ff == `LMF_LOCK_KEY) begin
            page_sel_out <= wr_data_in;                                             // see RULE20
            lock_ff      <= `LMF_LOCK_CLR;                                          // see RULE20
        end
    end
    assign page_lock_open_out = (lock_ff == `LMF_LOCK_KEY);

    // Function registers
    always @(posedge clk_in) begin
        if (srst_in || soft_rst) begin                                              // see RULE17 see RULE18
            cfg_ff      <= `LMF_RST_CFG;
            gcur_ff     <= `LMF_RST_GCUR;
            pull_ff     <= `LMF_RST_PULL;
            therm_ff    <= `LMF_RST_THERM;
            spread_ff   <= `LMF_RST_SPREAD;
            pfunlock_ff <= `LMF_RST_PFUNLOCK;
            pfsel_ff    <= `LMF_RST_PFSEL;
        end else if (pg1_wr) begin
            case (wr_addr_in)
                `LMF_OFF_CFG:      cfg_ff      <= wr_data_in & `LMF_MASK_CFG;      // see RULE24
                `LMF_OFF_GCUR:     gcur_ff     <= wr_data_in;
                `LMF_OFF_PULL:     pull_ff     <= wr_data_in & `LMF_MASK_PULL;     // see RULE24
                `LMF_OFF_THERM:    therm_ff    <= wr_data_in & `LMF_MASK_THERM;    // see RULE24
                `LMF_OFF_SPREAD:   spread_ff   <= wr_data_in & `LMF_MASK_SPREAD;   // see RULE24
                `LMF_OFF_PFUNLOCK: pfunlock_ff <= wr_data_in & `LMF_MASK_PFUNLOCK; // see RULE24
                `LMF_OFF_PFSEL: begin
                    if (pfunlock_ff[0]) begin                                       // see RULE19 see RULE23
                        pfsel_ff <= wr_data_in[7:5];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Detection launches on a step from disabled into a mode
    assign fd_now = cfg_ff[2:1];
    always @(posedge clk_in) begin
        if (srst_in) begin
            fd_prev_ff             <= `LMF_FD_OFF;
            open_detect_pulse_out  <= 1'b0;
            short_detect_pulse_out <= 1'b0;
        end else begin
            fd_prev_ff             <= fd_now;
            open_detect_pulse_out  <= (fd_prev_ff == `LMF_FD_OFF)
                                      && (fd_now == `LMF_FD_OPEN_A || fd_now == `LMF_FD_OPEN_B); // see RULE4 see RULE5
            short_detect_pulse_out <= (fd_prev_ff == `LMF_FD_OFF) && (fd_now == `LMF_FD_SHORT);  // see RULE4 see RULE6
        end
    end

    assign global_current_level_out = gcur_ff;                                      // see RULE8
    assign phase_select_out         = pull_ff[7];                                   // see RULE9
    assign spread_enable_out        = spread_ff[4];                                 // see RULE14
    assign pwm_freq_select_out      = pfsel_ff;

    // Registered decodes
    always @(posedge clk_in) begin
        if (srst_in) begin
            row_count_out             <= 2'h3;
            scan_static_out           <= 1'b0;
            shutdown_out              <= 1'b1;
            {row_pulldown_always_out, row_pulldown_kohm_x2_out}   <= lmf_pull_dec(pull_rst[6:4]); // see RULE18
            {column_pullup_always_out, column_pullup_kohm_x2_out} <= lmf_pull_dec(pull_rst[2:0]); // see RULE18
            thermal_start_c_out       <= `LMF_TEMP_140;
            rolloff_pct_out           <= `LMF_PCT_100;
            spread_dev_pct_out        <= 6'h00;
            spread_cycle_us_out       <= 11'h000;
            pwm_freq_div_log2_out     <= 3'h0;
        end else begin
            shutdown_out <= ~cfg_ff[0];                                             // see RULE7
            case (cfg_ff[7:4])                                                      // see RULE3
                `LMF_SCAN_THREE: begin
                    row_count_out   <= 2'h2;
                    scan_static_out <= 1'b0;
                end
                `LMF_SCAN_TWO: begin
                    row_count_out   <= 2'h1;
                    scan_static_out <= 1'b0;
                end
                `LMF_SCAN_STATIC: begin
                    row_count_out   <= 2'h0;
                    scan_static_out <= 1'b1;
                end
                default: begin
                    row_count_out   <= 2'h3;
                    scan_static_out <= 1'b0;
                end
            endcase
            {row_pulldown_always_out, row_pulldown_kohm_x2_out}   <= lmf_pull_dec(pull_ff[6:4]); // see RULE10
            {column_pullup_always_out, column_pullup_kohm_x2_out} <= lmf_pull_dec(pull_ff[2:0]); // see RULE11
            case (therm_ff[3:2])                                                    // see RULE12
                2'h0:    thermal_start_c_out <= `LMF_TEMP_140;
                2'h1:    thermal_start_c_out <= `LMF_TEMP_120;
                2'h2:    thermal_start_c_out <= `LMF_TEMP_100;
                default: thermal_start_c_out <= `LMF_TEMP_90;
            endcase
            case (therm_ff[1:0])                                                    // see RULE13
                2'h0:    rolloff_pct_out <= `LMF_PCT_100;
                2'h1:    rolloff_pct_out <= `LMF_PCT_75;
                2'h2:    rolloff_pct_out <= `LMF_PCT_55;
                default: rolloff_pct_out <= `LMF_PCT_30;
            endcase
            if (!spread_ff[4]) begin                                                // see RULE14
                spread_dev_pct_out  <= 6'h00;
                spread_cycle_us_out <= 11'h000;
            end else begin
                case (spread_ff[3:2])                                               // see RULE15
                    2'h0:    spread_dev_pct_out <= `LMF_DEV_5;
                    2'h1:    spread_dev_pct_out <= `LMF_DEV_15;
                    2'h2:    spread_dev_pct_out <= `LMF_DEV_24;
                    default: spread_dev_pct_out <= `LMF_DEV_34;
                endcase
                case (spread_ff[1:0])                                               // see RULE16
                    2'h0:    spread_cycle_us_out <= `LMF_CYC_1980;
                    2'h1:    spread_cycle_us_out <= `LMF_CYC_1200;
                    2'h2:    spread_cycle_us_out <= `LMF_CYC_820;
                    default: spread_cycle_us_out <= `LMF_CYC_660;
                endcase
            end
            if (pfsel_ff == `LMF_PFSEL_FAST_B) begin                                // see RULE22
                pwm_freq_div_log2_out <= 3'h0;
            end else begin
                pwm_freq_div_log2_out <= pfsel_ff;
            end
        end
    end
endmodule // lmf_func_regs

// ==== test/lmf_host_model.sv ====
/* Host write model that stands in for the serial slave's decoded writes.
   Assumes the bank takes a write at the edge where wr_stb_out is high. */
`timescale 1ns/1ps
`include "lmf_defines.vh"
module lmf_host_model (
    input  logic       clk_in,
    output logic       wr_stb_out,
    output logic [7:0] wr_header_out,
    output logic [7:0] wr_addr_out,
    output logic [7:0] wr_data_out
);
    initial begin
        wr_stb_out = 1'b0;
        wr_header_out = 8'h00;
        wr_addr_out = 8'h00;
        wr_data_out = 8'h00;
    end
    // One write; strobe stays high so calls may run back to back
    task automatic wr(input logic [7:0] h, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        wr_stb_out = 1'b1;
        wr_header_out = h;
        wr_addr_out = a;
        wr_data_out = d;
    endtask
    // Release; fields turn over so stale values never look valid
    task automatic idle;
        @(posedge clk_in);
        #1;
        wr_stb_out = 1'b0;
        wr_header_out = ~wr_header_out;
        wr_addr_out = ~wr_addr_out;
        wr_data_out = ~wr_data_out;
    endtask
    // Unlock the pointer, then point at page one
    task automatic page_one;
        wr(`LMF_HDR_LED, `LMF_OFF_LOCK, `LMF_LOCK_KEY);
        wr(`LMF_HDR_LED, `LMF_OFF_PAGE, `LMF_PAGE_ONE);
        idle();
    endtask
endmodule // lmf_host_model

// ==== test/lmf_func_regs_chk.sv ====
/* Port checker for the function register bank.
   Assumes a bind to lmf_func_regs, one clock, synchronous reset. */
`timescale 1ns/1ps
`include "lmf_defines.vh"
module lmf_func_regs_chk (
    input logic       clk_in,
    input logic       srst_in,
    input logic       wr_stb_in,
    input logic [7:0] wr_header_in,
    input logic [7:0] wr_addr_in,
    input logic [7:0] wr_data_in,
    input logic [7:0] page_sel_out,
    input logic       page_lock_open_out,
    input logic       open_detect_pulse_out,
    input logic       short_detect_pulse_out,
    input logic       shutdown_out,
    input logic [7:0] global_current_level_out,
    input logic       spread_enable_out,
    input logic [5:0] spread_dev_pct_out,
    input logic [2:0] pwm_freq_select_out
);
    logic freq_en_ff;
    logic nxt_freq_en;
    wire  hit = wr_stb_in && wr_header_in == `LMF_HDR_LED;
    wire  p1  = hit && page_sel_out == `LMF_PAGE_ONE;
    wire  cfg = p1 && wr_addr_in == `LMF_OFF_CFG;
    wire  pfw = p1 && wr_addr_in == `LMF_OFF_PFSEL;
    wire  srw = p1 && wr_addr_in == `LMF_OFF_RESET && wr_data_in == `LMF_RESET_KEY;
    // Mirror of the frequency unlock bit
    always @* begin
        nxt_freq_en = freq_en_ff;
        if (p1 && wr_addr_in == `LMF_OFF_PFUNLOCK)
            nxt_freq_en = wr_data_in[0];
        if (srw)
            nxt_freq_en = 1'b0;
    end
    always @(posedge clk_in)
        freq_en_ff <= srst_in ? 1'b0 : nxt_freq_en;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    sequence s_cfg_done;
        cfg ##2 1'b1;
    endsequence
    a_gcur_loads: assert property (
        p1 && wr_addr_in == `LMF_OFF_GCUR |=> global_current_level_out == $past(wr_data_in))
        else $error("global current not loaded");
    a_lock_opens: assert property (
        hit && wr_addr_in == `LMF_OFF_LOCK && wr_data_in == `LMF_LOCK_KEY |=> page_lock_open_out)
        else $error("lock key not taken");
    a_page_locked: assert property (
        hit && wr_addr_in == `LMF_OFF_PAGE && !page_lock_open_out |=> $stable(page_sel_out))
        else $error("locked page pointer changed");
    a_header_gate: assert property (
        wr_stb_in && wr_header_in != `LMF_HDR_LED |=> $stable(page_lock_open_out))
        else $error("foreign header acted on");
    a_shutdown_bit: assert property (
        s_cfg_done |-> shutdown_out == !$past(wr_data_in[0], 2))
        else $error("shutdown output wrong");
    a_open_single: assert property (
        open_detect_pulse_out |-> ($past(cfg, 2) || $past(cfg, 3)) ##1 !open_detect_pulse_out)
        else $error("open pulse without cause or too long");
    a_short_single: assert property (
        short_detect_pulse_out |-> !open_detect_pulse_out ##1 !short_detect_pulse_out)
        else $error("short pulse too long");
    a_freq_locked: assert property (
        pfw && !freq_en_ff |=> $stable(pwm_freq_select_out))
        else $error("locked frequency changed");
    a_freq_open: assert property (
        pfw && freq_en_ff |=> pwm_freq_select_out == $past(wr_data_in[7:5]))
        else $error("unlocked frequency not taken");
    a_spread_idle: assert property (
        !spread_enable_out [*2] |-> spread_dev_pct_out == 6'h00)
        else $error("spread range while disabled");
    a_soft_clear: assert property (
        srw |=> global_current_level_out == 8'h00 && !spread_enable_out)
        else $error("soft reset missed");
endmodule // lmf_func_regs_chk

// ==== test/tb_top.sv ====
/* Top testbench for the function register bank.
   Assumes lmf_host_model as write source and the checker bound below. */
`timescale 1ns/1ps
`include "lmf_defines.vh"
module tb_top;
    localparam logic [3:0]  KX2 [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h2, 4'h4, 4'h8, 4'h0};
    localparam logic [7:0]  TC [4]  = '{`LMF_TEMP_140, `LMF_TEMP_120, `LMF_TEMP_100, `LMF_TEMP_90};
    localparam logic [6:0]  PC [4]  = '{`LMF_PCT_100, `LMF_PCT_75, `LMF_PCT_55, `LMF_PCT_30};
    localparam logic [5:0]  DV [4]  = '{`LMF_DEV_5, `LMF_DEV_15, `LMF_DEV_24, `LMF_DEV_34};
    localparam logic [10:0] CY [4]  = '{`LMF_CYC_1980, `LMF_CYC_1200, `LMF_CYC_820, `LMF_CYC_660};
    logic       clk_in = 1'b0;
    logic       srst_in = 1'b1;
    logic [6:0] dot_sel_in = 7'h00;
    wire        stb;
    wire  [7:0] hdr, adr, dat;
    int         fails = 0, n_checks = 0, n_open = 0, n_short = 0;
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        if (i_dut.open_detect_pulse_out === 1'b1) n_open++;
        if (i_dut.short_detect_pulse_out === 1'b1) n_short++;
    end
    lmf_host_model i_host (.clk_in(clk_in), .wr_stb_out(stb), .wr_header_out(hdr), .wr_addr_out(adr),
        .wr_data_out(dat));
    lmf_func_regs i_dut (.clk_in(clk_in), .srst_in(srst_in), .wr_stb_in(stb), .wr_header_in(hdr),
        .wr_addr_in(adr), .wr_data_in(dat), .dot_sel_in(dot_sel_in), .dot_peak_scale_out(), .page_sel_out(),
        .page_lock_open_out(), .row_count_out(), .scan_static_out(), .open_detect_pulse_out(),
        .short_detect_pulse_out(), .shutdown_out(), .global_current_level_out(), .phase_select_out(),
        .row_pulldown_kohm_x2_out(), .row_pulldown_always_out(), .column_pullup_kohm_x2_out(),
        .column_pullup_always_out(), .thermal_start_c_out(), .rolloff_pct_out(), .spread_enable_out(),
        .spread_dev_pct_out(), .spread_cycle_us_out(), .pwm_freq_select_out(), .pwm_freq_div_log2_out(),
        .clear_busy_out());
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (fails == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One write, then let decode and launch pulses settle
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        i_host.wr(`LMF_HDR_LED, a, d);
        i_host.idle();
        repeat (3) @(posedge clk_in);
        #1;
    endtask
    task automatic t_defaults;
        chk(i_dut.page_sel_out, `LMF_PAGE_RST);
        chk(i_dut.global_current_level_out, `LMF_RST_GCUR);
        chk(i_dut.row_pulldown_kohm_x2_out, 4'h4);
        chk(i_dut.column_pullup_kohm_x2_out, 4'h4);
        chk(i_dut.shutdown_out, 1'b1);
        chk(i_dut.thermal_start_c_out, `LMF_TEMP_140);
    endtask
    task automatic t_page;
        put(`LMF_OFF_PAGE, `LMF_PAGE_ONE);
        chk(i_dut.page_sel_out, `LMF_PAGE_RST);
        i_host.wr(8'hAA, `LMF_OFF_LOCK, `LMF_LOCK_KEY);
        i_host.idle();
        chk(i_dut.page_lock_open_out, 1'b0);
        put(`LMF_OFF_GCUR, 8'h11);
        chk(i_dut.global_current_level_out, 8'h00);
        i_host.page_one();
        chk(i_dut.page_sel_out, `LMF_PAGE_ONE);
        chk(i_dut.page_lock_open_out, 1'b0);
    endtask
    task automatic t_dots;
        for (int i = 0; i < 200 && i_dut.clear_busy_out !== 1'b0; i++)
            @(posedge clk_in);
        put(`LMF_OFF_DOT_FIRST, 8'hA5);
        put(`LMF_OFF_DOT_LAST, 8'h3C);
        dot_sel_in = 7'h47;
        repeat (2) @(posedge clk_in);
        #1;
        chk(i_dut.dot_peak_scale_out, 8'h3C);
        dot_sel_in = 7'h00;
        repeat (2) @(posedge clk_in);
        #1;
        chk(i_dut.dot_peak_scale_out, 8'hA5);
    endtask
    task automatic t_scan;
        for (int c = 0; c < 6; c++) begin
            put(`LMF_OFF_CFG, {c[3:0], 4'h1});
            chk(i_dut.scan_static_out, c == 3);
            if (c != 3) chk(i_dut.row_count_out, c == 1 ? 2'h2 : c == 2 ? 2'h1 : 2'h3);
            chk(i_dut.shutdown_out, 1'b0);
        end
    endtask
    task automatic t_detect;
        int o;
        int s;
        o = n_open;
        s = n_short;
        put(`LMF_OFF_CFG, 8'h03);
        put(`LMF_OFF_CFG, 8'h03);
        put(`LMF_OFF_CFG, 8'h05);
        chk(11'(n_open - o), 11'h001);
        chk(11'(n_short - s), 11'h000);
        put(`LMF_OFF_CFG, 8'h01);
        put(`LMF_OFF_CFG, 8'h05);
        put(`LMF_OFF_CFG, 8'h01);
        put(`LMF_OFF_CFG, 8'h07);
        chk(11'(n_open - o), 11'h002);
        chk(11'(n_short - s), 11'h001);
    endtask
    task automatic t_tables;
        for (int c = 0; c < 8; c++) begin
            put(`LMF_OFF_PULL, {c[0], c[2:0], 1'b1, c[2:0]});
            chk(i_dut.phase_select_out, c[0]);
            chk(i_dut.row_pulldown_kohm_x2_out, KX2[c]);
            chk(i_dut.row_pulldown_always_out, c[2]);
            chk(i_dut.column_pullup_kohm_x2_out, KX2[c]);
            chk(i_dut.column_pullup_always_out, c[2]);
        end
        for (int i = 0; i < 4; i++) begin
            put(`LMF_OFF_THERM, {4'hF, i[1:0], i[1:0]});
            chk(i_dut.thermal_start_c_out, TC[i]);
            chk(i_dut.rolloff_pct_out, PC[i]);
            put(`LMF_OFF_SPREAD, {4'h1, i[1:0], i[1:0]});
            chk(i_dut.spread_dev_pct_out, DV[i]);
            chk(i_dut.spread_cycle_us_out, CY[i]);
        end
        put(`LMF_OFF_SPREAD, 8'h0F);
        chk(i_dut.spread_cycle_us_out, 11'h000);
    endtask
    task automatic t_pwm;
        put(`LMF_OFF_PFSEL, 8'hE0);
        chk(i_dut.pwm_freq_select_out, `LMF_RST_PFSEL);
        put(`LMF_OFF_PFUNLOCK, 8'h01);
        for (int c = 5; c < 8; c++) begin
            put(`LMF_OFF_PFSEL, {c[2:0], 5'h00});
            chk(i_dut.pwm_freq_select_out, c[2:0]);
            chk(i_dut.pwm_freq_div_log2_out, c == 7 ? 3'h0 : c[2:0]);
        end
        put(`LMF_OFF_PFUNLOCK, 8'h00);
        put(`LMF_OFF_PFSEL, 8'h20);
        chk(i_dut.pwm_freq_select_out, 3'h7);
    endtask
    task automatic t_soft;
        put(`LMF_OFF_GCUR, 8'hA5);
        chk(i_dut.global_current_level_out, 8'hA5);
        put(`LMF_OFF_RESET, 8'hAD);
        chk(i_dut.global_current_level_out, 8'hA5);
        put(`LMF_OFF_RESET, `LMF_RESET_KEY);
        chk(i_dut.global_current_level_out, `LMF_RST_GCUR);
        chk(i_dut.row_pulldown_kohm_x2_out, 4'h4);
        chk(i_dut.page_sel_out, `LMF_PAGE_ONE);
        dot_sel_in = 7'h47;
        chk(i_dut.clear_busy_out, 1'b1);
        repeat (72) @(posedge clk_in);
        #1;
        chk(i_dut.clear_busy_out, 1'b0);
        chk(i_dut.dot_peak_scale_out, `LMF_RST_DOT);
    endtask
    initial begin
        repeat (10) @(posedge clk_in);
        #1 srst_in = 1'b0;
        t_defaults();
        t_page();
        t_dots();
        t_scan();
        t_detect();
        t_tables();
        t_pwm();
        t_soft();
        final_report();
    end
    initial begin
        #200000;
        fails++;
        final_report();
    end
endmodule // tb_top
bind lmf_func_regs lmf_func_regs_chk i_chk (.clk_in(clk_in), .srst_in(srst_in), .wr_stb_in(wr_stb_in),
    .wr_header_in(wr_header_in), .wr_addr_in(wr_addr_in), .wr_data_in(wr_data_in), .page_sel_out(page_sel_out),
    .page_lock_open_out(page_lock_open_out), .open_detect_pulse_out(open_detect_pulse_out),
    .short_detect_pulse_out(short_detect_pulse_out), .shutdown_out(shutdown_out),
    .global_current_level_out(global_current_level_out), .spread_enable_out(spread_enable_out),
    .spread_dev_pct_out(spread_dev_pct_out), .pwm_freq_select_out(pwm_freq_select_out));
